/* File: inc/rtcrm_map.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef RTCRM_MAP_VH
`define RTCRM_MAP_VH
`define RTCRM_ADDR_CTRL1 5'h00
`define RTCRM_ADDR_CTRL2 5'h01
`define RTCRM_ADDR_TRIM 5'h02
`define RTCRM_ADDR_SPARE 5'h03
`define RTCRM_ADDR_SEC 5'h04
`define RTCRM_ADDR_MIN 5'h05
`define RTCRM_ADDR_HOUR 5'h06
`define RTCRM_ADDR_DAY 5'h07
`define RTCRM_ADDR_WDAY 5'h08
`define RTCRM_ADDR_MON 5'h09
`define RTCRM_ADDR_YEAR 5'h0A
`define RTCRM_ADDR_ASEC 5'h0B
`define RTCRM_ADDR_AMIN 5'h0C
`define RTCRM_ADDR_AHOUR 5'h0D
`define RTCRM_ADDR_ADAY 5'h0E
`define RTCRM_ADDR_AWDAY 5'h0F
`define RTCRM_ADDR_TVAL 5'h10
`define RTCRM_ADDR_TMODE 5'h11
`define RTCRM_ADDR_LAST 5'h11
`define RTCRM_NUM_REGS 18
`define RTCRM_BIT_EXTTEST 7
`define RTCRM_BIT_HALT 5
`define RTCRM_BIT_SOFTRST 4
`define RTCRM_BIT_CIE 2
`define RTCRM_BIT_H12 1
`define RTCRM_BIT_CAP 0
`define RTCRM_SOFTRST_CODE 8'h58
`define RTCRM_CTRL1_RESET 8'h00
`define RTCRM_TMODE_RESET 8'h18
`define RTCRM_CTRL1_MASK 8'hB7
`define RTCRM_SEC_RESET 8'h80
`define RTCRM_DAY_RESET 8'h01
`define RTCRM_ALARM_RESET 8'h80
`define RTCRM_TICK_HZ 1
`define RTCRM_CLK_HZ 40000000
`define RTCRM_TICK_CYCLES (`RTCRM_CLK_HZ / `RTCRM_TICK_HZ)
`define RTCRM_TRIM_CYCLES 2000000
`endif

/* File: verilog/rtcrm_regs.v */
// Register map, first control register and BCD timekeeping of the calendar clock
`timescale 1ns/100ps
`default_nettype none
`include "rtcrm_map.vh"

// Overview of operation
// - Absent bit positions have no storage
// - Reset loads defaults, control one cleared
// - Control one at 00h, bits 6,3 zero
// - Bit 7 selects external clock test mode
// - Bit 5 halts clock, clears divider
// - Bit 4 starts soft reset, reads zero
// - Bit 2 pulses interrupt each correction cycle
// - Bit 1 selects 12 or 24 hour
// - Bit 0 selects 7 or 12.5 pF
// - Address increments, wraps after 11h to 00h
// - Time and alarm registers are BCD
// - Counters freeze during register access
module rtcrm_regs #(
    parameter TICK_CYCLES = `RTCRM_TICK_CYCLES,
    parameter TRIM_CYCLES = `RTCRM_TRIM_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Register port from the serial interface
    input wire addrLoad,
    input wire [4:0] addrIn,
    input wire wrStrobe,
    input wire [7:0] wrData,
    input wire rdStrobe,
    input wire accessBusy,
    output wire [7:0] rdData,
    output wire [4:0] curAddr,
    // Test clock input
    input wire extClkPin,
    // Control outputs
    output wire extTestMode,
    output wire loadCapSelect,
    output wire hour12Mode,
    output wire correctionIrqPulse,
    output wire secondTick
);
    reg [7:0] regFile_ff [0:`RTCRM_NUM_REGS-1];
    reg [4:0] addr_ff;
    reg [31:0] div_ff;
    reg [31:0] trim_ff;
    reg irq_ff;
    reg tick_ff;
    reg extSync1_ff;
    reg extSync2_ff;
    reg extPrev_ff;
    reg [5:0] pre_ff;
    reg [4:0] nxt_addr;
    reg [7:0] secInc;
    reg [7:0] hourInc;
    reg [7:0] nxt_sec;
    reg [7:0] nxt_min;
    reg [7:0] nxt_hour;
    reg [7:0] nxt_wday;
    reg [7:0] nxt_day;
    reg [7:0] nxt_mon;
    reg [7:0] nxt_year;
    reg dayCarry;
    integer i;

    // Writable bits per register; absent bits never store
    function [7:0] wmask;
        input [4:0] a;
        begin
            case (a)
                `RTCRM_ADDR_CTRL1: wmask = `RTCRM_CTRL1_MASK;
                `RTCRM_ADDR_MIN: wmask = 8'h7F;
                `RTCRM_ADDR_HOUR: wmask = 8'h3F;
                `RTCRM_ADDR_DAY: wmask = 8'h3F;
                `RTCRM_ADDR_WDAY: wmask = 8'h07;
                `RTCRM_ADDR_MON: wmask = 8'h1F;
                `RTCRM_ADDR_AHOUR: wmask = 8'hBF;
                `RTCRM_ADDR_ADAY: wmask = 8'hBF;
                `RTCRM_ADDR_AWDAY: wmask = 8'h87;
                `RTCRM_ADDR_TMODE: wmask = 8'h1F;
                default: wmask = 8'hFF;
            endcase
        end
    endfunction

    // BCD increment with wrap from top to bottom
    function [7:0] bcdInc;
        input [7:0] v;
        input [7:0] top;
        input [7:0] bottom;
        begin
            if (v == top)
                bcdInc = bottom;
            else if (v[3:0] == 4'h9)
                bcdInc = {v[7:4] + 4'h1, 4'h0};
            else
                bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Two-digit year: every fourth year is a leap year.
    // Century rule not modelled; the year field cannot tell centuries apart.
    function leapYear;
        input [7:0] yr;
        begin
            if (yr[4] == 1'b0)
                leapYear = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
            else
                leapYear = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
        end
    endfunction

    // Last day of a BCD month
    function [7:0] monthLen;
        input [7:0] mon;
        input [7:0] yr;
        begin
            case (mon)
                8'h02: monthLen = leapYear(yr) ? 8'h29 : 8'h28;
                8'h04, 8'h06, 8'h09, 8'h11: monthLen = 8'h30;
                default: monthLen = 8'h31;
            endcase
        end
    endfunction

    wire [7:0] ctrl1 = regFile_ff[`RTCRM_ADDR_CTRL1];
    wire halted = ctrl1[`RTCRM_BIT_HALT];
    wire h12 = ctrl1[`RTCRM_BIT_H12];
    wire extTest = ctrl1[`RTCRM_BIT_EXTTEST];
    wire softReset = wrStrobe && (addr_ff == `RTCRM_ADDR_CTRL1) &&
        wrData[`RTCRM_BIT_SOFTRST];
    wire extRise = extSync2_ff && !extPrev_ff;
    wire freeze = accessBusy || wrStrobe || rdStrobe;
    wire [7:0] secNow = regFile_ff[`RTCRM_ADDR_SEC];
    wire [7:0] minNow = regFile_ff[`RTCRM_ADDR_MIN];
    wire [7:0] hourNow = regFile_ff[`RTCRM_ADDR_HOUR];
    wire [7:0] wdayNow = regFile_ff[`RTCRM_ADDR_WDAY];
    wire [7:0] dayNow = regFile_ff[`RTCRM_ADDR_DAY];
    wire [7:0] monNow = regFile_ff[`RTCRM_ADDR_MON];
    wire [7:0] yearNow = regFile_ff[`RTCRM_ADDR_YEAR];
    wire [7:0] lastDay = monthLen(monNow, yearNow);
    // Prescaler leaves halt at 31: 32 rises to the first tick, then 64 each
    wire tickNow = extTest ? (extRise && pre_ff == 6'h3E)
        : (div_ff == TICK_CYCLES - 1);

    assign rdData = (addr_ff <= `RTCRM_ADDR_LAST) ? regFile_ff[addr_ff] : 8'h00;
    assign curAddr = addr_ff;
    assign extTestMode = extTest;
    assign loadCapSelect = ctrl1[`RTCRM_BIT_CAP];
    assign hour12Mode = h12;
    assign correctionIrqPulse = irq_ff;
    assign secondTick = tick_ff;

    // Auto-increment with wrap past the last register
    always @*
    begin
        nxt_addr = addr_ff;
        if (addrLoad)
            nxt_addr = addrIn;
        else if (wrStrobe || rdStrobe)
            nxt_addr = (addr_ff >= `RTCRM_ADDR_LAST) ? 5'h00 : addr_ff + 5'h01;
    end

    // Next time and date values; the register block applies them on a tick
    always @*
    begin
        secInc = bcdInc({1'b0, secNow[6:0]}, 8'h59, 8'h00);
        nxt_sec = {secNow[7], secInc[6:0]};
        nxt_min = bcdInc(minNow, 8'h59, 8'h00);
        hourInc = bcdInc({3'b000, hourNow[4:0]}, 8'h12, 8'h01);
        nxt_hour = hourNow;
        dayCarry = 1'b0;
        if (h12)
        begin
            // 11 -> 12 flips the afternoon flag, 12 -> 1 keeps it
            if (hourNow[4:0] == 5'h11)
                nxt_hour = {2'b00, ~hourNow[5], 5'h12};
            else
                nxt_hour = {2'b00, hourNow[5], hourInc[4:0]};
            // Day ends where 11 in the afternoon becomes 12 at night
            dayCarry = hourNow[5] && (hourNow[4:0] == 5'h11);
        end
        else
        begin
            nxt_hour = bcdInc(hourNow, 8'h23, 8'h00);
            dayCarry = (hourNow == 8'h23);
        end
        nxt_wday = bcdInc(wdayNow, 8'h06, 8'h00);
        nxt_mon = monNow;
        nxt_year = yearNow;
        // A day past the month's end, left by a host write, rolls over too
        if (dayNow >= lastDay)
        begin
            nxt_day = 8'h01;
            if (monNow >= 8'h12)
            begin
                nxt_mon = 8'h01;
                nxt_year = bcdInc(yearNow, 8'h99, 8'h00);
            end
            else
                nxt_mon = bcdInc(monNow, 8'h12, 8'h01);
        end
        else
            nxt_day = bcdInc(dayNow, 8'h31, 8'h01);
    end

    // Test clock synchroniser
    always @(posedge clk)
    begin
        extSync1_ff <= extClkPin;
        extSync2_ff <= extSync1_ff;
        extPrev_ff <= extSync2_ff;
    end

    // Prescaler and correction cycle timing
    always @(posedge clk)
    begin
        if (reset || softReset || halted)
        begin
            div_ff <= 32'h0;
            pre_ff <= 6'h1F;
            trim_ff <= 32'h0;
            irq_ff <= 1'b0;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= tickNow;
            if (extTest)
            begin
                if (extRise)
                    pre_ff <= pre_ff + 6'h01;
            end
            else
                div_ff <= (div_ff == TICK_CYCLES - 1) ? 32'h0 : div_ff + 32'h1;
            trim_ff <= (trim_ff == TRIM_CYCLES - 1) ? 32'h0 : trim_ff + 32'h1;
            irq_ff <= ctrl1[`RTCRM_BIT_CIE] && (trim_ff == TRIM_CYCLES - 1);
        end
    end

    // Register file, host writes and calendar counting
    always @(posedge clk)
    begin
        if (reset || softReset)
        begin
            addr_ff <= 5'h00;
            for (i = 0; i < `RTCRM_NUM_REGS; i = i + 1)
                regFile_ff[i] <= 8'h00;
            regFile_ff[`RTCRM_ADDR_CTRL1] <= `RTCRM_CTRL1_RESET;
            regFile_ff[`RTCRM_ADDR_SEC] <= `RTCRM_SEC_RESET;
            regFile_ff[`RTCRM_ADDR_DAY] <= `RTCRM_DAY_RESET;
            regFile_ff[`RTCRM_ADDR_MON] <= `RTCRM_DAY_RESET;
            regFile_ff[`RTCRM_ADDR_ASEC] <= `RTCRM_ALARM_RESET;
            regFile_ff[`RTCRM_ADDR_AMIN] <= `RTCRM_ALARM_RESET;
            regFile_ff[`RTCRM_ADDR_AHOUR] <= `RTCRM_ALARM_RESET;
            regFile_ff[`RTCRM_ADDR_ADAY] <= `RTCRM_ALARM_RESET;
            regFile_ff[`RTCRM_ADDR_AWDAY] <= `RTCRM_ALARM_RESET;
            regFile_ff[`RTCRM_ADDR_TMODE] <= `RTCRM_TMODE_RESET;
        end
        else
        begin
            addr_ff <= nxt_addr;
            if (wrStrobe && addr_ff <= `RTCRM_ADDR_LAST)
                regFile_ff[addr_ff] <= wrData & wmask(addr_ff);
            else if (tickNow && !freeze)
            begin
                // Time only advances with no access in progress
                regFile_ff[`RTCRM_ADDR_SEC] <= nxt_sec;
                if (secNow[6:0] == 7'h59)
                begin
                    regFile_ff[`RTCRM_ADDR_MIN] <= nxt_min;
                    if (minNow == 8'h59)
                    begin
                        regFile_ff[`RTCRM_ADDR_HOUR] <= nxt_hour;
                        if (dayCarry)
                        begin
                            regFile_ff[`RTCRM_ADDR_WDAY] <= nxt_wday;
                            regFile_ff[`RTCRM_ADDR_DAY] <= nxt_day;
                            regFile_ff[`RTCRM_ADDR_MON] <= nxt_mon;
                            regFile_ff[`RTCRM_ADDR_YEAR] <= nxt_year;
                        end
                    end
                end
            end
        end
    end
endmodule // rtcrm_regs
`default_nettype wire

/* File: verification/rtcrm_regs_props.sv */
// Assertion checker for the calendar clock register block
`timescale 1ns/100ps
`default_nettype none
module rtcrm_regs_props #(
    parameter TICK_CYCLES = 20,
    parameter TRIM_CYCLES = 7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic addrLoad,
    input wire logic wrStrobe,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic [4:0] curAddr,
    input wire logic extTestMode,
    input wire logic loadCapSelect,
    input wire logic hour12Mode,
    input wire logic correctionIrqPulse
);
    logic [7:0] lastWr_ff;
    wire logic ctlWr = wrStrobe && !addrLoad && curAddr == 5'h00 && !wrData[4];
    wire logic ptrStep = wrStrobe && !addrLoad && !(curAddr == 5'h00 && wrData[4]);
    always @(posedge clk) lastWr_ff <= wrData;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_resv; curAddr == 5'h00 |-> rdData[6] == 1'b0 && rdData[3] == 1'b0; endproperty
    a_resv: assert property (p_resv) else $error("unused bits set");
    property p_srd; curAddr == 5'h00 |-> rdData[4] == 1'b0; endproperty
    a_srd: assert property (p_srd) else $error("reset bit reads one");
    property p_inc; ptrStep && curAddr < 5'h11 |=> curAddr == $past(curAddr) + 5'h01; endproperty
    a_inc: assert property (p_inc) else $error("pointer step");
    property p_wrap; ptrStep && curAddr == 5'h11 |=> curAddr == 5'h00; endproperty
    a_wrap: assert property (p_wrap) else $error("pointer wrap");
    property p_ext; ctlWr |=> extTestMode == lastWr_ff[7]; endproperty
    a_ext: assert property (p_ext) else $error("test mode bit");
    property p_mode; ctlWr |=> {hour12Mode, loadCapSelect} == lastWr_ff[1:0]; endproperty
    a_mode: assert property (p_mode) else $error("mode bits");
    property p_rst; $fell(reset) |-> curAddr == 5'h00 && rdData == 8'h00
        && !extTestMode && !hour12Mode && !loadCapSelect; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_irq; correctionIrqPulse |=> !correctionIrqPulse; endproperty
    a_irq: assert property (p_irq) else $error("irq pulse width");
endmodule // rtcrm_regs_props
bind rtcrm_regs rtcrm_regs_props #(.TICK_CYCLES(TICK_CYCLES), .TRIM_CYCLES(TRIM_CYCLES)) u_props (
    .clk(clk), .reset(reset), .addrLoad(addrLoad), .wrStrobe(wrStrobe), .wrData(wrData),
    .rdData(rdData), .curAddr(curAddr), .extTestMode(extTestMode),
    .loadCapSelect(loadCapSelect), .hour12Mode(hour12Mode),
    .correctionIrqPulse(correctionIrqPulse));
`default_nettype wire

/* File: verification/rtcrm_host_model.sv */
// Host model driving the register port
`timescale 1ns/100ps
`default_nettype none
module rtcrm_host_model (
    input wire logic clk,
    output logic addrLoad,
    output logic [4:0] addrIn,
    output logic wrStrobe,
    output logic [7:0] wrData,
    output logic rdStrobe,
    output logic accessBusy,
    input wire logic [7:0] rdData
);
    // Busy from time zero keeps the counters still until a test frees them
    initial
    begin
        {addrLoad, wrStrobe, rdStrobe} = '0;
        accessBusy = 1'b1;
    end
    task automatic busy(input logic b);
        accessBusy <= b;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        addrLoad <= 1'b1;
        addrIn <= a;
        @(posedge clk);
        addrLoad <= 1'b0;
        wrStrobe <= 1'b1;
        wrData <= d;
        @(posedge clk);
        wrStrobe <= 1'b0;
        wrData <= ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        addrLoad <= 1'b1;
        addrIn <= a;
        @(posedge clk);
        addrLoad <= 1'b0;
        rdStrobe <= 1'b1;
        @(posedge clk);
        d = rdData;
        rdStrobe <= 1'b0;
    endtask
    task automatic soft_reset;
        wr(5'h00, 8'h58);
    endtask
endmodule // rtcrm_host_model
`default_nettype wire

/* File: verification/rtcrm_regs_tb_top.sv */
// Self-checking bench for the calendar clock register block
`timescale 1ns/100ps
`default_nettype none
module rtcrm_regs_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic extClk = 1'b0;
    logic addrLoad, wrStrobe, rdStrobe, accessBusy, extTestMode, loadCapSelect;
    logic hour12Mode, correctionIrqPulse, secondTick;
    logic [4:0] addrIn, curAddr;
    logic [7:0] wrData, rdData, v;
    int num_errors = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    rtcrm_host_model host (.clk(clk), .addrLoad(addrLoad), .addrIn(addrIn),
        .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
        .accessBusy(accessBusy), .rdData(rdData));
    // Short counts keep second ticks and correction cycles within reach
    rtcrm_regs #(.TICK_CYCLES(20), .TRIM_CYCLES(7)) dut (.clk(clk), .reset(reset),
        .addrLoad(addrLoad), .addrIn(addrIn), .wrStrobe(wrStrobe), .wrData(wrData),
        .rdStrobe(rdStrobe), .accessBusy(accessBusy), .rdData(rdData), .curAddr(curAddr),
        .extClkPin(extClk), .extTestMode(extTestMode), .loadCapSelect(loadCapSelect),
        .hour12Mode(hour12Mode), .correctionIrqPulse(correctionIrqPulse),
        .secondTick(secondTick));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
            begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic run(output int nt, output int ni);
        nt = 0;
        ni = 0;
        host.busy(1'b0);
        repeat (60)
        begin
            @(posedge clk);
            nt += (secondTick === 1'b1);
            ni += (correctionIrqPulse === 1'b1);
        end
        host.busy(1'b1);
    endtask
    task automatic t_defaults;
        for (int i = 0; i < 18; i++)
            rchk(i[4:0], (i == 4 || (i > 10 && i < 16)) ? 8'h80 : (i == 7 || i == 9) ? 8'h01
                : (i == 17) ? 8'h18 : 8'h00);
    endtask
    task automatic t_soft;
        host.wr(5'h03, 8'h55);
        host.wr(5'h00, 8'h03);
        host.soft_reset;
        rchk(5'h03, 8'h00);
        rchk(5'h00, 8'h00);
    endtask
    task automatic t_ctrl;
        int nt, ni;
        host.wr(5'h00, 8'hAF);
        rchk(5'h00, 8'hA7);
        chk("modes", 8'h07, {5'h00, extTestMode, hour12Mode, loadCapSelect});
        host.wr(5'h00, 8'h20);
        run(nt, ni);
        chk("halted", 8'h00, {nt[3:0], ni[3:0]});
        host.wr(5'h00, 8'h04);
        run(nt, ni);
        chk("running", 8'h11, {3'h0, nt > 0, 3'h0, ni > 0});
    endtask
    task automatic t_wrap;
        host.wr(5'h08, 8'hFF);
        host.wr(5'h11, 8'hFF);
        @(posedge clk);
        chk("pointer", 8'h00, {3'h0, curAddr});
        rchk(5'h08, 8'h07);
        rchk(5'h11, 8'h1F);
    endtask
    task automatic t_carry;
        int n = 0;
        host.wr(5'h00, 8'h02);
        host.wr(5'h04, 8'h59);
        host.wr(5'h05, 8'h59);
        host.wr(5'h06, 8'h11);
        host.busy(1'b0);
        while (secondTick !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        host.busy(1'b1);
        rchk(5'h04, 8'h00);
        rchk(5'h05, 8'h00);
        rchk(5'h06, 8'h32);
        repeat (60) @(posedge clk);
        rchk(5'h04, 8'h00);
    endtask
    // Slow pulses so each rise clears the two-flop synchroniser
    task automatic pulses(input int n);
        repeat (n)
        begin
            extClk <= 1'b1;
            repeat (3) @(posedge clk);
            extClk <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic t_ext;
        host.wr(5'h00, 8'hA0);
        host.wr(5'h04, 8'h00);
        host.wr(5'h00, 8'h80);
        host.busy(1'b0);
        pulses(31);
        rchk(5'h04, 8'h00);
        pulses(1);
        rchk(5'h04, 8'h01);
        host.busy(1'b1);
        host.wr(5'h00, 8'h00);
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_defaults;
        t_soft;
        t_ctrl;
        t_wrap;
        t_carry;
        t_ext;
        wrap_up;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up;
    end
endmodule // rtcrm_regs_tb_top
`default_nettype wire
